// ==== adp_pkg.sv ====
/*
 Shared constants, field layout and types for the serial ready port.
 Assumes a 200 MHz system clock and a 16-bit conversion word.
*/
`default_nettype none
package adp_pkg;
	// =====================================================
	// Timing
	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned TMO_MS = 28;
	// Longest clock-low time in cycles, exact product
	localparam int unsigned TMO_CYC = TMO_MS * 1000 * CLK_MHZ;

	// =====================================================
	// Word and buffer
	localparam int unsigned WORD_W = 16;
	localparam int unsigned FIFO_DEPTH = 8;
	localparam logic [4:0] BITS_PER_WORD = 5'h10;
	localparam logic [3:0] BIT_MSB = 4'hF;
	localparam logic [3:0] RX_LAST = 4'hF;

	// =====================================================
	// Configuration word layout
	localparam logic [15:0] CFG_RST = 16'h058B;
	localparam int unsigned MUX_HI = 14;
	localparam int unsigned MUX_LO = 12;
	localparam int unsigned FSR_HI = 11;
	localparam int unsigned FSR_LO = 9;
	localparam int unsigned PULL_BIT = 3;
	localparam int unsigned WV_HI = 2;
	localparam int unsigned WV_LO = 1;
	localparam int unsigned RSVD_BIT = 0;
	localparam logic [1:0] WV_OK = 2'h1;

	// =====================================================
	// Input pairing
	typedef enum logic [2:0] {
		ANALOG_IN_ZERO = 3'h0,
		ANALOG_IN_ONE = 3'h1,
		ANALOG_IN_TWO = 3'h2,
		ANALOG_IN_THREE = 3'h3,
		ANALOG_GND = 3'h4
	} adp_inp_t;

	typedef struct packed {
		adp_inp_t pos;
		adp_inp_t neg;
	} adp_pair_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_SHIFT = 4'b0010,
		ST_DONE = 4'b0100,
		ST_ABORT = 4'b1000
	} adp_state_t;

	function automatic adp_pair_t mux_pair(input logic [2:0] m);
		adp_pair_t p;
		p = '{pos: ANALOG_IN_ZERO, neg: ANALOG_IN_ONE};
		case (m)
			3'h1: p = '{pos: ANALOG_IN_ZERO, neg: ANALOG_IN_THREE};
			3'h2: p = '{pos: ANALOG_IN_ONE, neg: ANALOG_IN_THREE};
			3'h3: p = '{pos: ANALOG_IN_TWO, neg: ANALOG_IN_THREE};
			3'h4: p = '{pos: ANALOG_IN_ZERO, neg: ANALOG_GND};
			3'h5: p = '{pos: ANALOG_IN_ONE, neg: ANALOG_GND};
			3'h6: p = '{pos: ANALOG_IN_TWO, neg: ANALOG_GND};
			3'h7: p = '{pos: ANALOG_IN_THREE, neg: ANALOG_GND};
			default: p = '{pos: ANALOG_IN_ZERO, neg: ANALOG_IN_ONE};
		endcase
		return p;
	endfunction
endpackage
`default_nettype wire

// ==== adp_sync.sv ====
/*
 Three-flop input synchroniser with agreement filter, one lane per bit.
 Assumes inputs are asynchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module adp_sync #(
	parameter int unsigned W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	// =====================================================
	// Per-bit lanes
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_lane
			logic s1_r, s2_r, s3_r, q_r, q_nxt;
			always_comb begin
				q_nxt = (s2_r == s3_r) ? s3_r : q_r;
			end
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					s1_r <= INIT[g];
					s2_r <= INIT[g];
					s3_r <= INIT[g];
					q_r <= INIT[g];
				end else begin
					s1_r <= d_i[g];
					s2_r <= s1_r;
					s3_r <= s2_r;
					q_r <= q_nxt;
				end
			end
			assign q_o[g] = q_r;
		end
	endgenerate
endmodule
`default_nettype wire

// ==== adp_fifo.sv ====
/*
 Synchronous FIFO holding finished conversion words.
 Assumes a power-of-two depth; both sides on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module adp_fifo #(
	parameter int unsigned W = 16,
	parameter int unsigned D = 8
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int unsigned AW = $clog2(D);
	localparam int unsigned CW = $clog2(D + 1);

	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic room_r, room_nxt, empty_r, empty_nxt;
	logic push, pop;

	// =====================================================
	// Pointers and flags
	always_comb begin
		push = in_valid_i && room_r;
		pop = out_ready_i && !empty_r;
		wp_nxt = push ? wp_r + 1'b1 : wp_r;
		rp_nxt = pop ? rp_r + 1'b1 : rp_r;
		cnt_nxt = cnt_r;
		if (push && !pop) begin
			cnt_nxt = cnt_r + 1'b1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 1'b1;
		end
		// Ready is kept as a flop so the top output needs no gate
		room_nxt = (cnt_nxt != CW'(D));
		empty_nxt = (cnt_nxt == '0);
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			room_r <= 1'b1;
			empty_r <= 1'b1;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
			room_r <= room_nxt;
			empty_r <= empty_nxt;
		end
	end

	// Storage has no reset; empty_r guards every read
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wp_r] <= in_data_i;
		end
	end

	assign in_ready_o = room_r;
	assign out_valid_o = !empty_r;
	assign out_data_o = mem[rp_r];
endmodule
`default_nettype wire

// ==== adp_port.sv ====
/*
 Serial host port of a delta-sigma converter: shared data-out/ready line,
 configuration intake and result readout through an 8-word buffer.
 Assumes a serial master in mode 1 on sclk_i, cs_n_i, din_i, and a
 conversion core pushing results on clk_i.
*/
// Summary of operation
// - Deselected line weakly pulled high by default
// - Pull-up bit cleared: deselected line floats
// - No ready indication while deselected
// - Chip select low: drive line at once
// - Low after select means fresh result
// - High means repeat last read result
// - Readout word stays stable during conversions
// - Single-ended pairing measures channel against ground
// - Convert only the currently selected pairing
// - First three inputs against fourth available
// - Mode 1: launch rising, sample falling
// - Clock low over 28 ms abandons transfer
// - Update configuration only on write-valid 01
`timescale 1ns/1ps
`default_nettype none
module adp_port #(
	parameter int unsigned TMO_CYC = adp_pkg::TMO_CYC,
	parameter int unsigned DEPTH = adp_pkg::FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic din_i,
	output logic data_out_ready_line_o,
	output logic data_out_ready_line_oe_o,
	output logic data_out_ready_line_pull_o,
	input wire logic res_valid_i,
	output logic res_ready_o,
	input wire logic [adp_pkg::WORD_W-1:0] res_data_i,
	output logic [adp_pkg::WORD_W-1:0] cfg_o,
	output var adp_pkg::adp_pair_t pair_o,
	output logic [2:0] full_scale_range_o
);
	localparam int unsigned TW = $clog2(TMO_CYC + 1);
	localparam int unsigned WW = adp_pkg::WORD_W;

	// =====================================================
	// Link domain: capture on falling sclk edges
	logic link_rst_n;
	logic [WW-2:0] rx_sh_r, rx_sh_nxt;
	logic [3:0] rx_cnt_r, rx_cnt_nxt;
	logic [WW-1:0] rx_word_r, rx_word_nxt;
	logic rx_tgl_r, rx_tgl_nxt;

	// Frame counter is held clear while deselected
	assign link_rst_n = rst_n_i && !cs_n_i;

	always_comb begin
		rx_sh_nxt = {rx_sh_r[WW-3:0], din_i};
		rx_cnt_nxt = rx_cnt_r + 1'b1;
		rx_word_nxt = rx_word_r;
		rx_tgl_nxt = rx_tgl_r;
		if (rx_cnt_r == adp_pkg::RX_LAST) begin
			rx_word_nxt = {rx_sh_r, din_i};
			rx_tgl_nxt = !rx_tgl_r;
		end
	end

	always_ff @(negedge sclk_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			rx_sh_r <= '0;
			rx_cnt_r <= '0;
		end else begin
			rx_sh_r <= rx_sh_nxt;
			rx_cnt_r <= rx_cnt_nxt;
		end
	end

	// Word is held a whole frame, so the toggle alone crosses
	always_ff @(negedge sclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_word_r <= '0;
			rx_tgl_r <= 1'b0;
		end else begin
			rx_word_r <= rx_word_nxt;
			rx_tgl_r <= rx_tgl_nxt;
		end
	end

	// =====================================================
	// Pin and toggle synchronisers
	logic sclk_q, cs_q, tgl_q;

	adp_sync #(.W(3), .INIT(3'h2)) u_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.d_i({rx_tgl_r, cs_n_i, sclk_i}),
		.q_o({tgl_q, cs_q, sclk_q})
	);

	// =====================================================
	// Result buffer
	logic fifo_valid, pop;
	logic [WW-1:0] fifo_data;

	adp_fifo #(.W(WW), .D(DEPTH)) u_fifo (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(res_valid_i),
		.in_ready_o(res_ready_o),
		.in_data_i(res_data_i),
		.out_valid_o(fifo_valid),
		.out_ready_i(pop),
		.out_data_o(fifo_data)
	);

	// =====================================================
	// System domain state
	adp_pkg::adp_state_t st_r, st_nxt;
	logic sclk_d_r, tgl_d_r;
	logic [4:0] bit_cnt_r, bit_cnt_nxt;
	logic [TW-1:0] tmo_r, tmo_nxt;
	logic [WW-1:0] tx_r, tx_nxt, last_r, last_nxt, cfg_r, cfg_nxt;
	logic fresh_r, fresh_nxt;
	logic data_r, data_nxt, oe_r, oe_nxt, pull_r, pull_nxt;
	adp_pkg::adp_pair_t pair_r, pair_nxt;
	logic rise, fall, word_evt;

	always_comb begin
		rise = sclk_q && !sclk_d_r;
		fall = !sclk_q && sclk_d_r;
		word_evt = (tgl_q != tgl_d_r);
		pop = (st_r == adp_pkg::ST_SHIFT) && !cs_q && fall && fresh_r
			&& (bit_cnt_r == adp_pkg::BITS_PER_WORD);
		st_nxt = st_r;
		bit_cnt_nxt = bit_cnt_r;
		tmo_nxt = tmo_r;
		tx_nxt = tx_r;
		last_nxt = last_r;
		fresh_nxt = fresh_r;
		data_nxt = data_r;
		oe_nxt = oe_r;
		pull_nxt = pull_r;
		cfg_nxt = cfg_r;
		if (cs_q) begin
			// Deselected: no ready indication, pull or float
			st_nxt = adp_pkg::ST_IDLE;
			oe_nxt = 1'b0;
			data_nxt = 1'b1;
			pull_nxt = cfg_r[adp_pkg::PULL_BIT];
			bit_cnt_nxt = '0;
			tmo_nxt = '0;
		end else begin
			unique case (st_r)
				adp_pkg::ST_IDLE: begin
					oe_nxt = 1'b1;
					pull_nxt = 1'b0;
					if (fifo_valid) begin
						tx_nxt = fifo_data;
						fresh_nxt = 1'b1;
						data_nxt = 1'b0;
					end else begin
						tx_nxt = last_r;
						fresh_nxt = 1'b0;
						data_nxt = 1'b1;
					end
					st_nxt = adp_pkg::ST_SHIFT;
				end
				adp_pkg::ST_SHIFT, adp_pkg::ST_DONE: begin
					tmo_nxt = (sclk_q || rise) ? '0 : tmo_r + 1'b1;
					if (rise) begin
						if (bit_cnt_r < adp_pkg::BITS_PER_WORD) begin
							// Launch on rising edge
							data_nxt = tx_r[adp_pkg::BIT_MSB - bit_cnt_r[3:0]];
							bit_cnt_nxt = bit_cnt_r + 1'b1;
						end else begin
							data_nxt = 1'b0;
						end
					end
					if (pop) begin
						last_nxt = tx_r;
						fresh_nxt = 1'b0;
						st_nxt = adp_pkg::ST_DONE;
					end
					if (tmo_r == TW'(TMO_CYC - 1)) begin
						st_nxt = adp_pkg::ST_ABORT;
					end
				end
				adp_pkg::ST_ABORT: begin
					tmo_nxt = '0;
				end
			endcase
		end
		// Words of an abandoned frame are dropped
		if (word_evt && (st_r != adp_pkg::ST_ABORT)
			&& (rx_word_r[adp_pkg::WV_HI:adp_pkg::WV_LO] == adp_pkg::WV_OK)) begin
			cfg_nxt = rx_word_r;
			cfg_nxt[adp_pkg::RSVD_BIT] = 1'b1;
		end
		// One pairing at a time from the mux field
		pair_nxt = adp_pkg::mux_pair(cfg_r[adp_pkg::MUX_HI:adp_pkg::MUX_LO]);
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r <= adp_pkg::ST_IDLE;
			sclk_d_r <= 1'b0;
			tgl_d_r <= 1'b0;
			bit_cnt_r <= '0;
			tmo_r <= '0;
			tx_r <= '0;
			last_r <= '0;
			fresh_r <= 1'b0;
			data_r <= 1'b1;
			oe_r <= 1'b0;
			pull_r <= adp_pkg::CFG_RST[adp_pkg::PULL_BIT];
			cfg_r <= adp_pkg::CFG_RST;
			pair_r <= adp_pkg::mux_pair(adp_pkg::CFG_RST[adp_pkg::MUX_HI:adp_pkg::MUX_LO]);
		end else begin
			st_r <= st_nxt;
			sclk_d_r <= sclk_q;
			tgl_d_r <= tgl_q;
			bit_cnt_r <= bit_cnt_nxt;
			tmo_r <= tmo_nxt;
			tx_r <= tx_nxt;
			last_r <= last_nxt;
			fresh_r <= fresh_nxt;
			data_r <= data_nxt;
			oe_r <= oe_nxt;
			pull_r <= pull_nxt;
			cfg_r <= cfg_nxt;
			pair_r <= pair_nxt;
		end
	end

	assign data_out_ready_line_o = data_r;
	assign data_out_ready_line_oe_o = oe_r;
	assign data_out_ready_line_pull_o = pull_r;
	assign cfg_o = cfg_r;
	assign pair_o = pair_r;
	assign full_scale_range_o = cfg_r[adp_pkg::FSR_HI:adp_pkg::FSR_LO];

	// =====================================================
	// Assertions
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_WEAK_PULL: assert property (
		cs_q && $past(cs_q) && $stable(cfg_r) && cfg_r[adp_pkg::PULL_BIT]
		|=> pull_r && !oe_r && data_r)
		else $error("deselected line not weakly pulled");

	AST_FLOAT: assert property (
		cs_q && $past(cs_q) && $stable(cfg_r) && !cfg_r[adp_pkg::PULL_BIT]
		|=> !pull_r && !oe_r)
		else $error("deselected line not floating");

	AST_NO_READY_IDLE: assert property (
		cs_q && $past(cs_q) |-> !oe_r && data_r)
		else $error("ready shown while deselected");

	AST_DRIVE_ON_SELECT: assert property (
		$fell(cs_q) |=> oe_r && !pull_r)
		else $error("line not driven after select");

	AST_READY_LOW: assert property (
		$fell(cs_q) && fifo_valid |=> !data_r && fresh_r && tx_r == $past(fifo_data))
		else $error("fresh result not flagged low");

	AST_REPEAT_LAST: assert property (
		$fell(cs_q) && !fifo_valid |=> data_r && !fresh_r && tx_r == $past(last_r))
		else $error("last read result not repeated");

	AST_TX_STABLE: assert property (
		st_r == adp_pkg::ST_SHIFT && !cs_q |=> $stable(tx_r) || cs_q)
		else $error("readout word changed mid frame");

	AST_LAUNCH: assert property (
		st_r == adp_pkg::ST_SHIFT && !cs_q && rise && bit_cnt_r < adp_pkg::BITS_PER_WORD
		|=> data_r == $past(tx_r[adp_pkg::BIT_MSB - bit_cnt_r[3:0]]))
		else $error("wrong bit launched");

	AST_TIMEOUT: assert property (
		st_r == adp_pkg::ST_SHIFT && !cs_q && tmo_r == TW'(TMO_CYC - 1)
		|=> st_r == adp_pkg::ST_ABORT)
		else $error("transfer not abandoned on clock timeout");

	AST_CFG_WRITE: assert property (
		word_evt && st_r != adp_pkg::ST_ABORT
		&& rx_word_r[adp_pkg::WV_HI:adp_pkg::WV_LO] == adp_pkg::WV_OK
		|=> cfg_r == {$past(rx_word_r[WW-1:1]), 1'b1})
		else $error("valid configuration not taken");

	AST_CFG_HOLD: assert property (
		!(word_evt && rx_word_r[adp_pkg::WV_HI:adp_pkg::WV_LO] == adp_pkg::WV_OK)
		|=> $stable(cfg_r))
		else $error("configuration changed without write-valid");

	AST_PAIR: assert property (
		$stable(cfg_r) |-> pair_r == adp_pkg::mux_pair(cfg_r[adp_pkg::MUX_HI:adp_pkg::MUX_LO]))
		else $error("pairing does not follow mux field");

	AST_CONSUMED: assert property (
		pop |=> !fresh_r && last_r == $past(tx_r))
		else $error("clocked-out result still fresh");

	COV_FRESH_READ: cover property (pop);
	COV_STALE_POLL: cover property ($fell(cs_q) && !fifo_valid);
	COV_CFG_WRITE: cover property (word_evt && st_r != adp_pkg::ST_ABORT);
	COV_FULL: cover property (!res_ready_o);
endmodule
`default_nettype wire

// ==== adp_master.sv ====
/*
 Behavioural serial master facing the ready port, mode 1, 125 ns link clock.
 Assumes the bench resolves the shared data-out/ready pin onto line_i.
*/
`timescale 1ns/1ps
`default_nettype none
module adp_master (
	output logic sclk_o,
	output logic cs_n_o,
	output logic din_o,
	input wire logic line_i
);
	// =====================================
	// Idle state
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		din_o = 1'b0;
	end

	// =====================================
	// One frame; stall of 0 to 15 holds the clock low past the timeout, -1 never stalls
	task automatic frame(input logic [15:0] tx, input int stall, output logic first,
		output logic [15:0] rx);
		cs_n_o = 1'b0;
		// Odd offset keeps the link clock out of phase with the system clock
		#101.3;
		first = line_i;
		for (int i = 15; i >= 0; i--) begin
			if (i == stall) begin
				#1500;
			end
			sclk_o = 1'b1;
			din_o = tx[i];
			#62.5;
			sclk_o = 1'b0;
			rx[i] = line_i;
			#62.5;
		end
		cs_n_o = 1'b1;
		// Released data line must not keep its last level
		din_o = ~din_o;
		#300;
	endtask
endmodule
`default_nettype wire

// ==== test_adc_serial_data_ready_port.sv ====
/*
 Self-checking bench for the serial ready port with a behavioural master.
 Assumes adp_pkg, adp_fifo, adp_sync, adp_port and adp_master are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_adc_serial_data_ready_port;
	logic clk_i;
	logic rst_n_i = 1'b0;
	logic res_valid_i = 1'b0;
	logic [15:0] res_data_i = 16'h0000;
	wire logic sclk;
	wire logic cs_n;
	wire logic din;
	logic line, oe, pull, res_ready, first;
	logic [15:0] cfg, rx, last_rd, cw, keep;
	adp_pkg::adp_pair_t pair;
	logic [2:0] full_scale_range, fv;
	logic [1:0] wvs [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
	logic [15:0] exp_q [$];
	int fails = 0;
	int n_compared = 0;
	int acc;
	// Floating pin modelled as the inverse of the idle level
	wire logic pin = oe ? line : (pull ? 1'b1 : ~line);

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	adp_port #(.TMO_CYC(200), .DEPTH(8)) dut (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
		.data_out_ready_line_o(line), .data_out_ready_line_oe_o(oe),
		.data_out_ready_line_pull_o(pull), .res_valid_i(res_valid_i),
		.res_ready_o(res_ready), .res_data_i(res_data_i), .cfg_o(cfg), .pair_o(pair),
		.full_scale_range_o(full_scale_range)
	);
	adp_master m (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .line_i(pin));

	// =====================================
	// Checking helpers
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic test_done;
		$display("compared %0d, failures %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	function automatic logic [15:0] cfg_word(input logic [2:0] mx, input logic [2:0] f,
		input logic pu, input logic [1:0] wv);
		// Continuous mode, 64 SPS rate code
		return {1'b0, mx, f, 1'b0, 3'h3, 1'b0, pu, wv, 1'b1};
	endfunction

	function automatic logic [5:0] exp_pair(input logic [2:0] mx);
		if (mx == 3'h0) return 6'h01;
		if (mx < 3'h4) return {mx - 3'h1, 3'h3};
		return {mx - 3'h4, 3'h4};
	endfunction

	// =====================================
	// Result pushes, first two are bit-order corners
	task automatic fill(input int tries, output int n);
		logic took;
		n = 0;
		@(posedge clk_i);
		for (int i = 0; i < tries; i++) begin
			res_valid_i <= 1'b1;
			res_data_i <= (i == 0) ? 16'h8000 : (i == 1) ? 16'h0001 : 16'($urandom);
			// Ready is read mid-cycle, before the edge that takes the word
			@(negedge clk_i);
			took = (res_ready === 1'b1);
			@(posedge clk_i);
			if (took) begin
				exp_q.push_back(res_data_i);
				n++;
			end
		end
		res_valid_i <= 1'b0;
	endtask

	// =====================================
	// Main sequence
	initial begin
		void'($urandom(32'h578ec869));
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		chk("cfg reset", 16'h058B, cfg);
		chk("pull idle", 16'h0001, {15'h0, pull});
		chk("oe idle", 16'h0000, {15'h0, oe});
		chk("pair reset", 16'h0001, {10'h0, pair});
		repeat (4) @(posedge clk_i);
		fill(10, acc);
		chk("accepted", 16'h0008, 16'(acc));
		chk("push ready", 16'h0000, {15'h0, res_ready});
		repeat (40) begin
			@(posedge clk_i);
			chk("oe deselected", 16'h0000, {15'h0, oe});
		end
		for (int k = 0; k < 8; k++) begin
			fv = (k == 7) ? 3'h4 : 3'(k);
			cw = cfg_word(3'(k), fv, 1'b1, 2'h1);
			m.frame(cw, -1, first, rx);
			last_rd = exp_q.pop_front();
			chk("ready level", 16'h0000, {15'h0, first});
			chk("readout", last_rd, rx);
			chk("config", cw, cfg);
			chk("pair", {10'h0, exp_pair(3'(k))}, {10'h0, pair});
			chk("range", {13'h0, fv}, {13'h0, full_scale_range});
		end
		keep = cfg;
		for (int k = 0; k < 4; k++) begin
			cw = cfg_word(3'h6, 3'h1, 1'b0, wvs[k]);
			if (k == 3) keep = cw;
			m.frame(cw, -1, first, rx);
			chk("ready level", 16'h0001, {15'h0, first});
			chk("readout", last_rd, rx);
			chk("config", keep, cfg);
		end
		chk("pull off", 16'h0000, {15'h0, pull});
		chk("oe off", 16'h0000, {15'h0, oe});
		fork
			m.frame(cfg_word(3'h5, 3'h1, 1'b1, 2'h1), 8, first, rx);
			begin
				#400;
				fill(1, acc);
			end
		join
		chk("ready level", 16'h0001, {15'h0, first});
		chk("config", keep, cfg);
		m.frame(cfg_word(3'h2, 3'h2, 1'b1, 2'h1), -1, first, rx);
		chk("ready level", 16'h0000, {15'h0, first});
		chk("readout", exp_q.pop_front(), rx);
		test_done;
	end

	// Hang guard
	initial begin
		#200000;
		fails++;
		test_done;
	end
endmodule
`default_nettype wire
